// file: scip_defs.svh
// timing, function codes and buffer constants for the coprocessor two-wire port
`ifndef SCIP_DEFS_SVH
`define SCIP_DEFS_SVH
`define SCIP_CLK_MHZ        200
`define SCIP_WAKE_LOW_US    60
`define SCIP_WAKE_HIGH_US   1500
`define SCIP_WATCHDOG_MS    1300
`define SCIP_FN_RESET       8'h00
`define SCIP_FN_SLEEP       8'h01
`define SCIP_FN_IDLE        8'h02
`define SCIP_FN_CMD         8'h03
`define SCIP_BUF_BYTES      71
`define SCIP_DEF_ADDR       7'h60
`define SCIP_BYTE_BITS      4'd8
`define SCIP_PEND_NONE      2'd0
`define SCIP_PEND_SLEEP     2'd1
`define SCIP_PEND_IDLE      2'd2
`endif

// file: scip_pkg.sv
// types for the coprocessor two-wire port
package scip_pkg;
  typedef enum logic [2:0] {
    SCIP_ASLEEP = 3'b000,
    SCIP_WAKING = 3'b001,
    SCIP_AWAKE  = 3'b010,
    SCIP_IDLE   = 3'b011,
    SCIP_BUSY   = 3'b100
  } scip_pwr_t;
  typedef enum logic [2:0] {
    SCIP_BUS_FREE = 3'b000,
    SCIP_BUS_ADDR = 3'b001,
    SCIP_BUS_FUNC = 3'b010,
    SCIP_BUS_DATA = 3'b011,
    SCIP_BUS_SKIP = 3'b100
  } scip_bus_t;
endpackage

// file: scip_sync.sv
// three-flop synchroniser with glitch-free edge reporting for one pin
module scip_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // pin in
  input  wire logic pin_i,
  // synchronised level and edges
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } scip_sync_st_t;
  scip_sync_st_t st;
  scip_sync_st_t next_st;
  // s1 feeds only s2; edges are seen between s2 and s3
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  assign level_o = st.s3;
  assign rise_o  = st.s2 & ~st.s3;
  assign fall_o  = ~st.s2 & st.s3;
endmodule // scip_sync

// file: scip_port.sv
// two-wire target port of the security coprocessor: wake, framing, function codes, command fifo
`include "scip_defs.svh"
module scip_port #(
  parameter int unsigned BUF_BYTES    = `SCIP_BUF_BYTES,
  parameter int unsigned WAKE_LOW_US  = `SCIP_WAKE_LOW_US,
  parameter int unsigned WAKE_HIGH_CY = `SCIP_WAKE_HIGH_US * `SCIP_CLK_MHZ,
  parameter int unsigned WATCHDOG_CY  = `SCIP_WATCHDOG_MS * 1000 * `SCIP_CLK_MHZ
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // two-wire pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // configuration
  input  wire logic [6:0] bus_addr_i,
  // command engine
  input  wire logic       exec_done_i,
  output logic            exec_start_o,
  output logic            wr_valid_o,
  output logic [7:0]      wr_data_o,
  output logic [6:0]      wr_index_o,
  output logic            vol_clear_o,
  output logic            keep_key_o,
  output logic            awake_o,
  output logic            busy_o
);
  // ==========================================================
  // constants
  // one cycle past the wake-low time, so a low of exactly that length is no wake
  localparam int unsigned WAKE_LOW_CY = (WAKE_LOW_US * `SCIP_CLK_MHZ) + 1;
  localparam int unsigned IDXW        = 7;
  // one width for all timers; the default watchdog count needs 28 bits
  localparam int unsigned TW          = 32;
  // elaboration checks; the write index is seven bits, so the buffer stays below 128
  if (BUF_BYTES < 4 || BUF_BYTES > 127) begin : g_bad_buf
    $error("scip_port: buffer size out of range");
  end
  if (WAKE_HIGH_CY < 2 || WATCHDOG_CY < 2) begin : g_bad_tmr
    $error("scip_port: timing counts too small");
  end
  if (WAKE_LOW_US < 1) begin : g_bad_wake
    $error("scip_port: wake-low time must be at least one microsecond");
  end

  // ==========================================================
  // pin synchronisers
  // about three cycles of latency: the host must hold each scl phase well beyond that
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  scip_sync u_scl (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (scl_i),
    .level_o   (scl_lvl),
    .rise_o    (scl_rise),
    .fall_o    (scl_fall)
  );
  scip_sync u_sda (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (sda_i),
    .level_o   (sda_lvl),
    .rise_o    (sda_rise),
    .fall_o    (sda_fall)
  );

  // ==========================================================
  // state
  typedef struct packed {
    scip_pkg::scip_pwr_t pwr;
    scip_pkg::scip_bus_t bus;
    logic [TW-1:0]       tmr;     // wake-low and wake-high timer
    logic [TW-1:0]       wdog;
    logic [3:0]          bitn;
    logic [7:0]          shreg;
    logic                ack_ph;  // inside ninth clock
    logic [IDXW-1:0]     wptr;
    logic [7:0]          count;
    logic                have_cnt;
    logic [1:0]          pend;    // 1 sleep, 2 idle on stop
    logic                sda_o;
    logic                sda_oe;
    logic                exec_start;
    logic                wr_valid;
    logic [7:0]          wr_data;
    logic [IDXW-1:0]     wr_index;
    logic                vol_clear;
    logic                keep_key;
    logic                awake;
    logic                busy;
  } scip_st_t;
  scip_st_t st;
  scip_st_t next_st;

  // decoded bus events; start and stop see scl through the same synchroniser delay
  // byte_done marks the eighth scl fall outside the ninth-clock phase
  logic scl_en;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic [7:0] byte_val;
  assign scl_en    = (st.pwr == scip_pkg::SCIP_AWAKE) || (st.pwr == scip_pkg::SCIP_BUSY);
  assign start_ev  = scl_en && scl_lvl && sda_fall;
  assign stop_ev   = scl_en && scl_lvl && sda_rise;
  assign byte_done = scl_en && scl_fall && !st.ack_ph && (st.bitn == `SCIP_BYTE_BITS);
  assign byte_val  = st.shreg;

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st            = st;
    next_st.exec_start = 1'b0;
    next_st.wr_valid   = 1'b0;
    next_st.vol_clear  = 1'b0;
    unique case (st.pwr)
      scip_pkg::SCIP_ASLEEP, scip_pkg::SCIP_IDLE: begin
        // framing is dropped, so a wake always starts from a free bus
        next_st.bus    = scip_pkg::SCIP_BUS_FREE;
        next_st.sda_oe = 1'b0;
        // only a long sda low counts; scl is not looked at
        if (!sda_lvl) begin
          if (st.tmr >= TW'(WAKE_LOW_CY)) begin
            next_st.pwr  = scip_pkg::SCIP_WAKING;
            next_st.tmr  = '0;
          end else begin
            next_st.tmr  = st.tmr + 1'b1;
          end
        end else begin
          next_st.tmr = '0;
        end
      end
      scip_pkg::SCIP_WAKING: begin
        // bus sensing opens at the end of the wake-high delay
        // sda is not watched here, so a second long low during the delay is harmless
        if (st.tmr >= TW'(WAKE_HIGH_CY - 1)) begin
          next_st.pwr   = scip_pkg::SCIP_AWAKE;
          next_st.tmr   = '0;
          next_st.wdog  = '0;
          next_st.bitn  = '0;
          next_st.ack_ph = 1'b0;
        end else begin
          next_st.tmr = st.tmr + 1'b1;
        end
      end
      scip_pkg::SCIP_AWAKE, scip_pkg::SCIP_BUSY: begin
        // long sda lows while awake are just bits, not wakes
        next_st.wdog = st.wdog + 1'b1;
        // end of execution empties the buffer, so the next write starts with a count
        if (st.pwr == scip_pkg::SCIP_BUSY && exec_done_i) begin
          next_st.pwr      = scip_pkg::SCIP_AWAKE;
          next_st.have_cnt = 1'b0;
          next_st.wptr     = '0;
        end
        // a start restarts framing even mid-byte and drops a pending sleep or idle
        if (start_ev) begin
          next_st.bus    = scip_pkg::SCIP_BUS_ADDR;
          next_st.bitn   = '0;
          next_st.ack_ph = 1'b0;
          next_st.sda_oe = 1'b0;
          next_st.pend   = `SCIP_PEND_NONE;
        end else if (stop_ev) begin
          // the stop closes the transaction; sleep, idle and execution start wait for it
          next_st.bus    = scip_pkg::SCIP_BUS_FREE;
          next_st.sda_oe = 1'b0;
          if (st.pend == `SCIP_PEND_SLEEP) begin
            // sleep drops the key registers as well
            next_st.pwr       = scip_pkg::SCIP_ASLEEP;
            next_st.vol_clear = 1'b1;
            next_st.keep_key  = 1'b0;
            next_st.wptr      = '0;
            next_st.have_cnt  = 1'b0;
            next_st.tmr       = '0;
          end else if (st.pend == `SCIP_PEND_IDLE) begin
            // idle keeps key and seed but flushes the buffer
            next_st.pwr      = scip_pkg::SCIP_IDLE;
            next_st.keep_key = 1'b1;
            next_st.wptr     = '0;
            next_st.have_cnt = 1'b0;
            next_st.tmr      = '0;
          end else if (st.pwr == scip_pkg::SCIP_AWAKE && st.have_cnt &&
                       ({1'b0, st.wptr} >= st.count)) begin
            next_st.pwr        = scip_pkg::SCIP_BUSY;
            next_st.exec_start = 1'b1;
          end
          next_st.pend = `SCIP_PEND_NONE;
        end else if (scl_en && scl_rise && !st.ack_ph &&
                     st.bus != scip_pkg::SCIP_BUS_FREE) begin
          // sample on synchronised scl rise; sda has been settled for half a bit
          next_st.shreg = {st.shreg[6:0], sda_lvl};   // msb first
          next_st.bitn  = st.bitn + 1'b1;
        end else if (byte_done) begin
          // eighth fall: decide the ninth-clock answer while scl is low
          next_st.bitn   = '0;
          next_st.ack_ph = 1'b1;
          next_st.sda_oe = 1'b0;
          next_st.sda_o  = 1'b0;
          unique case (st.bus)
            scip_pkg::SCIP_BUS_ADDR: begin
              if (byte_val[7:1] == bus_addr_i) begin
                if (byte_val[0]) begin
                  // busy reads are not acked; mid-command reads while awake are
                  if (st.pwr == scip_pkg::SCIP_AWAKE) begin
                    next_st.sda_oe = 1'b1;
                  end
                  next_st.bus = scip_pkg::SCIP_BUS_SKIP;
                end else if (st.pwr == scip_pkg::SCIP_AWAKE) begin
                  next_st.sda_oe = 1'b1;
                  next_st.bus    = scip_pkg::SCIP_BUS_FUNC;
                end else begin
                  next_st.bus = scip_pkg::SCIP_BUS_SKIP;
                end
              end else begin
                next_st.bus = scip_pkg::SCIP_BUS_SKIP;
              end
            end
            scip_pkg::SCIP_BUS_FUNC: begin
              // second byte picks the function; only the command code opens a data phase
              next_st.sda_oe = 1'b1;
              next_st.bus    = scip_pkg::SCIP_BUS_SKIP;
              if (byte_val == `SCIP_FN_RESET) begin
                next_st.wptr     = '0;
                next_st.have_cnt = 1'b0;
              end else if (byte_val == `SCIP_FN_SLEEP) begin
                next_st.pend = `SCIP_PEND_SLEEP;
              end else if (byte_val == `SCIP_FN_IDLE) begin
                next_st.pend = `SCIP_PEND_IDLE;
              end else if (byte_val == `SCIP_FN_CMD) begin
                next_st.bus = scip_pkg::SCIP_BUS_DATA;
              end else begin
                next_st.sda_oe = 1'b0;                 // reserved code left unacked
              end
            end
            scip_pkg::SCIP_BUS_DATA: begin
              // count-limited fifo, capped at buffer end
              if ((!st.have_cnt || ({1'b0, st.wptr} < st.count)) &&
                  (32'(st.wptr) < BUF_BYTES)) begin
                next_st.sda_oe   = 1'b1;
                next_st.wr_valid = 1'b1;
                next_st.wr_data  = byte_val;
                next_st.wr_index = st.wptr;
                next_st.wptr     = st.wptr + 1'b1;
                if (!st.have_cnt) begin
                  next_st.have_cnt = 1'b1;
                  next_st.count    = byte_val;
                end
              end
            end
            default: begin
              next_st.sda_oe = 1'b0;
            end
          endcase
        end else if (scl_en && scl_fall && st.ack_ph) begin
          // ninth fall: let go of sda while scl is low again
          next_st.ack_ph = 1'b0;                       // release after ninth clock
          next_st.sda_o  = 1'b0;
          // a selected read sends all ones: the line is simply released
          next_st.sda_oe = 1'b0;
        end
        // watchdog forces sleep and drops volatile data
        // it also counts while busy, so a long execution may end in an immediate sleep
        if (st.pwr == scip_pkg::SCIP_AWAKE && st.wdog >= TW'(WATCHDOG_CY - 1)) begin
          next_st.pwr       = scip_pkg::SCIP_ASLEEP;
          next_st.bus       = scip_pkg::SCIP_BUS_FREE;
          next_st.sda_oe    = 1'b0;
          next_st.vol_clear = 1'b1;
          next_st.keep_key  = 1'b0;
          next_st.wptr      = '0;
          next_st.have_cnt  = 1'b0;
          next_st.tmr       = '0;
          next_st.wr_valid  = 1'b0;
          next_st.exec_start = 1'b0;
        end
      end
      default: begin
        next_st.pwr = scip_pkg::SCIP_ASLEEP;
      end
    endcase
    // level outputs follow the next power state, so they too come from flops
    next_st.awake = (next_st.pwr == scip_pkg::SCIP_AWAKE) || (next_st.pwr == scip_pkg::SCIP_BUSY);
    next_st.busy  = (next_st.pwr == scip_pkg::SCIP_BUSY);
  end

  // ==========================================================
  // state register
  // reset leaves the port asleep with every pulse and the pin enable low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st          <= '0;
      st.pwr      <= scip_pkg::SCIP_ASLEEP;
      st.bus      <= scip_pkg::SCIP_BUS_FREE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from state flops
  // sda_o stays low: the pin is open drain and only its enable moves
  assign sda_o        = st.sda_o;
  assign sda_oe_o     = st.sda_oe;
  assign exec_start_o = st.exec_start;
  assign wr_valid_o   = st.wr_valid;
  assign wr_data_o    = st.wr_data;
  assign wr_index_o   = st.wr_index;
  assign vol_clear_o  = st.vol_clear;
  assign keep_key_o   = st.keep_key;
  assign awake_o      = st.awake;
  assign busy_o       = st.busy;
endmodule // scip_port

// file: scip_port_props.sv
// assertion checker bound to the coprocessor two-wire port
module scip_port_props (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       srst_i,
  // pins
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [6:0] bus_addr_i,
  // command engine
  input wire logic       exec_done_i,
  input wire logic       exec_start_o,
  input wire logic       wr_valid_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [6:0] wr_index_o,
  input wire logic       vol_clear_o,
  input wire logic       keep_key_o,
  input wire logic       awake_o,
  input wire logic       busy_o
);
  // ==================
  // properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  AST_QUIET_ASLEEP: assert property (!awake_o && !$past(awake_o) |-> !sda_oe_o)
    else $error("sda pulled while not awake");
  AST_OPEN_DRAIN: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  AST_ACK_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved with scl high");
  AST_EXEC_BUSY: assert property (exec_start_o |=> busy_o && !exec_start_o)
    else $error("start without busy");
  AST_BUSY_HOLDS: assert property (busy_o && !exec_done_i |=> busy_o)
    else $error("busy dropped early");
  AST_WRITE_BOUND: assert property (wr_valid_o |-> !busy_o && awake_o && wr_index_o < 7'd71)
    else $error("byte taken out of range");
  AST_SLEEP_CLEARS: assert property (vol_clear_o |-> ##[0:1] (!awake_o && !keep_key_o))
    else $error("clear without sleep");
  AST_IDLE_KEEPS: assert property ($rose(keep_key_o) |-> ##[0:1] (!awake_o && !vol_clear_o))
    else $error("idle entry wrong");
endmodule // scip_port_props

bind scip_port scip_port_props u_props (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_addr_i(bus_addr_i), .exec_done_i(exec_done_i),
  .exec_start_o(exec_start_o), .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_index_o(wr_index_o),
  .vol_clear_o(vol_clear_o), .keep_key_o(keep_key_o), .awake_o(awake_o), .busy_o(busy_o));

// file: scip_host_model.sv
// two-wire bus host model, open-drain pulls on both lines
module scip_host_model #(
  parameter int H = 12
) (
  // clock
  input  wire logic clk_sys_i,
  // resolved data wire
  input  wire logic sda_i,
  // pulls, high means line held low
  output logic      scl_low_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================
  // bus idle: both lines left to the pull-ups
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // step n edges, then just past the edge
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // sda falls while scl high
  task automatic start_c();
    sda_low_o = 1'b0;
    hw(2);
    scl_low_o = 1'b0;
    hw(H);
    sda_low_o = 1'b1;
    hw(H);
    scl_low_o = 1'b1;
    hw(2);
  endtask
  // sda rises while scl high, closing every write
  task automatic stop_c();
    sda_low_o = 1'b1;
    hw(2);
    scl_low_o = 1'b0;
    hw(H);
    sda_low_o = 1'b0;
    hw(H);
  endtask
  // data set only while scl low
  task automatic put_bit(input logic b);
    sda_low_o = !b;
    hw(H);
    scl_low_o = 1'b0;
    hw(H);
    scl_low_o = 1'b1;
    hw(2);
  endtask
  // msb first, then release sda for the ninth clock
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_low_o = 1'b0;
    hw(H);
    scl_low_o = 1'b0;
    hw(H - 1);
    ack = !sda_i;
    hw(1);
    scl_low_o = 1'b1;
    hw(2);
  endtask
  // long low on sda with scl idle
  task automatic wake(input int n);
    sda_low_o = 1'b1;
    hw(n);
    sda_low_o = 1'b0;
    hw(H);
  endtask
endmodule // scip_host_model

// file: scip_port_test.sv
// self-checking testbench for the coprocessor two-wire port
module scip_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ==================
  // signals
  localparam logic [7:0] WA = 8'hb4;
  localparam logic [7:0] RA = 8'hb5;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        exec_done_i = 1'b0;
  logic [6:0]  bus_addr_i = 7'h5a;
  logic        scl_low, sda_low, sda_o, sda_oe_o, exec_start_o, wr_valid_o;
  logic        vol_clear_o, keep_key_o, awake_o, busy_o;
  logic [7:0]  wr_data_o;
  logic [6:0]  wr_index_o;
  logic [14:0] wq[$];
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_exec = 0;
  int          n_vol = 0;
  // pull-ups resolve both lines
  wire scl_w = !scl_low;
  wire sda_w = !(sda_low || (sda_oe_o && !sda_o));
  always #2.5 clk_sys_i = ~clk_sys_i;
  // ==================
  // design and host; short counts keep the run brief
  scip_port #(.WAKE_LOW_US(1), .WAKE_HIGH_CY(50), .WATCHDOG_CY(20000)) u_dut (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_addr_i(bus_addr_i),
    .exec_done_i(exec_done_i), .exec_start_o(exec_start_o), .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o),
    .wr_index_o(wr_index_o), .vol_clear_o(vol_clear_o), .keep_key_o(keep_key_o), .awake_o(awake_o),
    .busy_o(busy_o));
  scip_host_model u_host (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low));
  // pulses sampled mid-cycle, clear of the update edge
  always @(negedge clk_sys_i) begin
    if (wr_valid_o) wq.push_back({wr_index_o, wr_data_o});
    if (exec_start_o) n_exec++;
    if (vol_clear_o) n_vol++;
  end
  // ==================
  // helpers
  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one write or read transaction, ack of byte i in bit i
  task automatic txn(input logic [7:0] b[$], output logic [15:0] a);
    logic k;
    a = '0;
    u_host.start_c();
    foreach (b[i]) begin
      u_host.wr_byte(b[i], k);
      a[i] = k;
    end
    u_host.stop_c();
  endtask
  task automatic wake_up();
    u_host.wake(230);
    chk(16'(awake_o), 16'h0);
    u_host.hw(70);
    chk(16'(awake_o), 16'h1);
  endtask
  // ==================
  // scenarios
  task automatic t_basic();
    logic [15:0] a;
    txn('{WA, 8'h03}, a);
    chk(a, 16'h0);
    wake_up();
    txn('{8'h34, 8'h03}, a);
    chk(a, 16'h0);
    txn('{RA}, a);
    chk(a, 16'h1);
    // move the address so every bit of it changes
    bus_addr_i = 7'h25;
    txn('{WA}, a);
    chk(a, 16'h0);
    txn('{8'h4a, 8'h00}, a);
    chk(a, 16'h3);
    txn('{8'h4b}, a);
    chk(a, 16'h1);
    bus_addr_i = 7'h5a;
  endtask
  task automatic t_command();
    logic [15:0] a;
    logic [7:0]  d[4];
    d = '{8'h04, 8'ha1, 8'hb2, 8'hc3}; // count, one packet byte, two crc bytes
    wq.delete();
    txn('{WA, 8'h03, 8'h04, 8'ha1}, a);
    chk(a, 16'hf);
    u_host.wake(230);
    txn('{RA}, a);
    chk(a, 16'h1);
    txn('{WA, 8'h03, 8'hb2, 8'hc3, 8'hd4}, a);
    chk(a, 16'hf);
    chk(16'({n_exec[3:0], 3'h0, busy_o}), 16'h11);
    chk(16'(wq.size()), 16'h4);
    foreach (d[i]) chk(16'(wq[i]), 16'({7'(i), d[i]}));
    txn('{RA}, a);
    chk(a, 16'h0);
    u_host.hw(1);
    exec_done_i = 1'b1;
    u_host.hw(1);
    exec_done_i = 1'b0;
    u_host.hw(2);
    txn('{RA}, a);
    chk({a[0], busy_o}, 2'b10);
  endtask
  task automatic t_codes();
    logic [15:0] a;
    logic [7:0]  rsv[2];
    logic        k;
    int          v;
    rsv = '{8'h04, 8'hff};
    wq.delete();
    txn('{WA, 8'h03, 8'h05, 8'he1}, a);
    txn('{WA, 8'h00}, a);
    chk(a, 16'h3);
    txn('{WA, 8'h03, 8'h06}, a);
    chk(16'(wq[1]), 16'({7'h01, 8'he1}));
    chk(16'(wq[2]), 16'({7'h00, 8'h06}));
    foreach (rsv[i]) begin
      txn('{WA, rsv[i]}, a);
      chk(a, 16'h1);
    end
    v = n_vol;
    u_host.start_c();
    u_host.wr_byte(WA, k);
    u_host.wr_byte(8'h01, k);
    chk({k, awake_o}, 2'b11);
    u_host.stop_c();
    chk(16'({n_vol - v, awake_o, keep_key_o}), 16'h4);
    txn('{WA, 8'h03}, a);
    chk(a, 16'h0);
  endtask
  task automatic t_idle_watchdog();
    logic [15:0] a;
    int          v;
    wake_up();
    v = n_vol;
    txn('{WA, 8'h02}, a);
    chk(a, 16'h3);
    chk(16'({n_vol - v, awake_o, keep_key_o}), 16'h1);
    wake_up();
    u_host.hw(19400);
    chk(16'(awake_o), 16'h1);
    u_host.hw(1000);
    chk(16'({n_vol - v, awake_o}), 16'h2);
  endtask
  // ==================
  // main sequence and hang guard
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    u_host.hw(4);
    t_basic();
    t_command();
    t_codes();
    t_idle_watchdog();
    test_done();
  end
  initial begin
    #400000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule // scip_port_test
